// file: hw/ccl_logout.sv
// controller check logout: shadows per-level state, freezes it on an error
// assumes all inputs come from controller logic on ref_clk, no sync needed
`timescale 1ns/1ps
module ccl_logout #(
  parameter int DW = 16,
  parameter int AW = 16
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  // operation results
  input  wire logic                   op_valid,
  input  wire logic                   op_sets_flags,
  input  wire ccl_pkg::ccl_flags_t    op_flags,
  input  wire logic [7:0]             cur_level,
  // work register writes
  input  wire logic                   wr_we,
  input  wire logic [7:0]             wr_level,
  input  wire logic [2:0]             wr_idx,
  input  wire logic [DW-1:0]          wr_data,
  // microinstruction sequencing
  input  wire logic                   ex_valid,
  input  wire logic [7:0]             ex_level,
  input  wire logic [AW-1:0]          ex_addr,
  input  wire logic                   bl_valid,
  input  wire logic [7:0]             bl_level,
  input  wire logic [AW-1:0]          bl_addr,
  // error report
  input  wire logic                   err_strobe,
  input  wire ccl_pkg::ccl_ctl_err_t  err_ctl,
  input  wire ccl_pkg::ccl_chan_err_t err_chan,
  // register port
  input  wire logic [4:0]             reg_addr,
  input  wire logic [15:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [15:0]            reg_rdata,
  // status
  output logic                        irq,
  output logic                        frozen
);
  // ==========================================
  // level code to bank
  function automatic logic [2:0] bank_of(input logic [7:0] code);
    case (code)
      ccl_pkg::LVL_FIVE:  bank_of = 3'h0;
      ccl_pkg::LVL_FOUR:  bank_of = 3'h1;
      ccl_pkg::LVL_STEAL: bank_of = 3'h4; // steal runs on level one set
      ccl_pkg::LVL_THREE: bank_of = 3'h2;
      ccl_pkg::LVL_TWO:   bank_of = 3'h3;
      ccl_pkg::LVL_ONE:   bank_of = 3'h4;
      default:            bank_of = 3'h5;
    endcase
  endfunction

  // shared by the execute and link paths; wraps at the top of the space
  function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] addr);
    next_addr = addr + AW'(1);
  endfunction

  // ==========================================
  // live state
  ccl_pkg::ccl_flags_t flags_ff;
  logic [DW-1:0]       wreg_ff [ccl_pkg::NUM_BANKS][ccl_pkg::NUM_WREGS];
  logic [AW-1:0]       maddr_ff [ccl_pkg::NUM_BANKS];
  logic [AW-1:0]       mret_ff  [ccl_pkg::NUM_BANKS];

  wire logic       flag_upd = op_valid & op_sets_flags;
  wire logic [2:0] wr_bank  = bank_of(wr_level);
  wire logic [2:0] ex_bank  = bank_of(ex_level);
  wire logic [2:0] bl_bank  = bank_of(bl_level);
  wire logic [2:0] cur_bank = bank_of(cur_level);
  wire logic [AW-1:0] ex_next = next_addr(ex_addr);
  wire logic [AW-1:0] bl_next = next_addr(bl_addr);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flags_ff <= '0;
    end else if (flag_upd) begin
      flags_ff <= op_flags;
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int b = 0; b < ccl_pkg::NUM_BANKS; b++) begin
      for (int r = 0; r < ccl_pkg::NUM_WREGS; r++) begin
        if (reset) begin
          wreg_ff[b][r] <= '0;
        end else if (wr_we && wr_bank == 3'(b) && wr_idx == 3'(r)) begin
          wreg_ff[b][r] <= wr_data;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int b = 0; b < ccl_pkg::NUM_BANKS; b++) begin
      if (reset) begin
        maddr_ff[b] <= '0;
        mret_ff[b]  <= '0;
      end else begin
        if (ex_valid && ex_bank == 3'(b)) begin
          maddr_ff[b] <= ex_next;
        end
        if (bl_valid && bl_bank == 3'(b)) begin
          mret_ff[b] <= bl_next;
        end
      end
    end
  end

  // ==========================================
  // capture
  // the record takes the _ff values, so updates in the error cycle itself
  // stay out of the log
  // limitation: an execute in the error cycle itself is not the one logged
  ccl_pkg::ccl_flags_t   cap_flags_ff;
  ccl_pkg::ccl_ctl_err_t cap_ctl_ff;
  ccl_pkg::ccl_chan_err_t cap_chan_ff;
  logic [7:0]            cap_level_ff;
  logic                  cap_valid_ff;
  logic [DW-1:0]         cap_wreg_ff [ccl_pkg::NUM_WREGS];
  logic [AW-1:0]         cap_maddr_ff;
  logic [AW-1:0]         cap_mret_ff;
  logic                  frozen_ff;

  wire logic clear_wr = reg_wr & (reg_addr == ccl_pkg::REG_CTRL)
                        & reg_wdata[ccl_pkg::CTRL_CLEAR];
  wire logic take     = err_strobe & ~frozen_ff;
  wire logic dropped  = err_strobe & frozen_ff;
  wire logic lvl_bad  = err_chan.cycle_steal
                        & (err_chan.bad_dev_addr | err_chan.outbound_par);
  wire logic nxt_frozen = take | (frozen_ff & ~clear_wr);

  ccl_pkg::ccl_ctl_err_t  ctl_clean;
  ccl_pkg::ccl_chan_err_t chan_clean;
  always_comb begin
    ctl_clean         = err_ctl;
    ctl_clean.unused  = 2'h0;
    chan_clean        = err_chan;
    chan_clean.unused4 = 1'b0;
    chan_clean.unused7 = 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      frozen_ff <= 1'b0;
    end else begin
      frozen_ff <= nxt_frozen;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cap_flags_ff <= '0;
      cap_ctl_ff   <= '0;
      cap_chan_ff  <= '0;
      cap_level_ff <= ccl_pkg::BYTE_RESET;
      cap_valid_ff <= 1'b0;
      cap_maddr_ff <= '0;
      cap_mret_ff  <= '0;
    end else if (take) begin
      cap_flags_ff <= flags_ff;
      cap_ctl_ff   <= ctl_clean;
      cap_chan_ff  <= chan_clean;
      cap_level_ff <= cur_level;
      cap_valid_ff <= ~lvl_bad;
      cap_maddr_ff <= maddr_ff[cur_bank];
      cap_mret_ff  <= mret_ff[cur_bank];
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int r = 0; r < ccl_pkg::NUM_WREGS; r++) begin
      if (reset) begin
        cap_wreg_ff[r] <= '0;
      end else if (take) begin
        cap_wreg_ff[r] <= wreg_ff[cur_bank][r];
      end
    end
  end

  // ==========================================
  // interrupts
  logic [1:0] istat_ff;
  logic [1:0] imask_ff;
  logic       irq_ff;
  wire logic  istat_wr = reg_wr & (reg_addr == ccl_pkg::REG_ISTAT);
  wire logic  imask_wr = reg_wr & (reg_addr == ccl_pkg::REG_IMASK);
  wire logic [1:0] ev  = {dropped, take};
  // set wins over a write-one clear in the same cycle
  wire logic [1:0] nxt_istat = ev | (istat_ff & ~(istat_wr ? reg_wdata[1:0] : 2'h0));

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      istat_ff <= ccl_pkg::IRQ_RESET;
      imask_ff <= ccl_pkg::IRQ_RESET;
      irq_ff   <= 1'b0;
    end else begin
      istat_ff <= nxt_istat;
      imask_ff <= imask_wr ? reg_wdata[1:0] : imask_ff;
      irq_ff   <= |(nxt_istat & (imask_wr ? reg_wdata[1:0] : imask_ff));
    end
  end

  // ==========================================
  // read port; unmapped addresses read zero
  logic [15:0] rdata_ff;
  wire logic        hit_wreg = reg_addr[4:3] == ccl_pkg::REG_WREG_HI;
  wire logic [15:0] wreg_rd  = 16'(cap_wreg_ff[reg_addr[2:0]]);
  wire logic [15:0] rd_mux =
    hit_wreg                            ? wreg_rd :
    reg_addr == ccl_pkg::REG_FLAGS      ? {8'h00, cap_flags_ff} :
    reg_addr == ccl_pkg::REG_LEVEL      ? {8'h00, cap_level_ff} :
    reg_addr == ccl_pkg::REG_CTLERR     ? {8'h00, cap_ctl_ff} :
    reg_addr == ccl_pkg::REG_CHANERR    ? {8'h00, cap_chan_ff} :
    reg_addr == ccl_pkg::REG_STATE      ? {14'h0000, cap_valid_ff, frozen_ff} :
    reg_addr == ccl_pkg::REG_ISTAT      ? {14'h0000, istat_ff} :
    reg_addr == ccl_pkg::REG_IMASK      ? {14'h0000, imask_ff} :
    reg_addr == ccl_pkg::REG_MADDR      ? 16'(cap_maddr_ff) :
    reg_addr == ccl_pkg::REG_MRET       ? 16'(cap_mret_ff) :
    reg_addr == ccl_pkg::REG_LIVEFLG    ? {8'h00, flags_ff} :
                                          16'h0000;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq       = irq_ff;
  assign frozen    = frozen_ff;

  // ==========================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_flags_hold: assert property (
    !flag_upd |=> $stable(flags_ff))
    else $error("flags moved without a flag-affecting op");
  a_flags_load: assert property (
    flag_upd |=> flags_ff == $past(op_flags))
    else $error("flags did not take op result");
  a_freeze_hold: assert property (
    frozen_ff && !clear_wr |=> frozen_ff && $stable(cap_level_ff)
      && $stable(cap_ctl_ff) && $stable(cap_maddr_ff))
    else $error("frozen record changed");
  a_take_level: assert property (
    take |=> cap_level_ff == $past(cur_level) && frozen_ff)
    else $error("level code not captured");
  a_bad_level: assert property (
    take && err_chan.cycle_steal && err_chan.outbound_par |=> !cap_valid_ff)
    else $error("invalid level code marked valid");
  a_good_level: assert property (
    take && !err_chan.cycle_steal |=> cap_valid_ff)
    else $error("valid level code marked invalid");
  a_steal_bank: assert property (
    take && cur_level == ccl_pkg::LVL_STEAL
      |=> cap_wreg_ff[0] == $past(wreg_ff[4][0]))
    else $error("steal did not log level one set");
  a_maddr_plus: assert property (
    ex_valid && ex_level == ccl_pkg::LVL_MAIN
      |=> maddr_ff[5] == $past(ex_addr) + AW'(1))
    else $error("micro address not plus one");
  a_mret_link: assert property (
    bl_valid && bl_level == ccl_pkg::LVL_FIVE
      |=> mret_ff[0] == $past(bl_addr) + AW'(1))
    else $error("return address not after link");
  a_snap_flags: assert property (
    take |=> cap_flags_ff == $past(flags_ff))
    else $error("logged flags not from error moment");
  a_unused_zero: assert property (
    frozen_ff |-> cap_ctl_ff.unused == 2'h0 && !cap_chan_ff.unused4
      && !cap_chan_ff.unused7)
    else $error("unused check bits logged");
  a_irq_level: assert property (
    ##1 irq_ff == |($past(nxt_istat) & imask_ff))
    else $error("irq disagrees with status");
  a_read_late: assert property (
    !reg_rd |=> rdata_ff == 16'h0000)
    else $error("read data outside read cycle");

  // ==========================================
  // checks: live shadows
  a_wreg_shadow: assert property (
    wr_we && wr_level == ccl_pkg::LVL_THREE && wr_idx == 3'h5
      |=> wreg_ff[2][5] == $past(wr_data))
    else $error("work register write missed its bank");
  a_steal_shadow: assert property (
    ex_valid && ex_level == ccl_pkg::LVL_STEAL
      |=> maddr_ff[4] == $past(ex_addr) + AW'(1))
    else $error("steal address not kept in level one set");
  a_unknown_main: assert property (
    ex_valid && ex_level == 8'h06
      |=> maddr_ff[5] == $past(ex_addr) + AW'(1))
    else $error("unknown level code not on main set");
  a_maddr_hold: assert property (
    !ex_valid |=> $stable(maddr_ff[1]) && $stable(maddr_ff[3]))
    else $error("micro address moved with no execute");
  a_mret_hold: assert property (
    !bl_valid |=> $stable(mret_ff[0]) && $stable(mret_ff[5]))
    else $error("return address moved with no link");

  // ==========================================
  // checks: captured record
  a_cap_parity: assert property (
    take |=> cap_ctl_ff[3:0] == $past(err_ctl[3:0]))
    else $error("controller parity bits not logged");
  a_cap_addr_stat: assert property (
    take |=> cap_ctl_ff.addr_status == $past(err_ctl.addr_status))
    else $error("storage address status not logged");
  a_cap_chan: assert property (
    take |=> cap_chan_ff[6:5] == $past(err_chan[6:5])
      && cap_chan_ff[3:0] == $past(err_chan[3:0]))
    else $error("channel check bits not logged");
  a_bad_device: assert property (
    take && err_chan.cycle_steal && err_chan.bad_dev_addr |=> !cap_valid_ff)
    else $error("bad device steal marked valid");
  a_level_wregs: assert property (
    take && cur_level == ccl_pkg::LVL_FIVE
      |=> cap_wreg_ff[7] == $past(wreg_ff[0][7]))
    else $error("level five set not logged");
  a_main_wregs: assert property (
    take && cur_level == ccl_pkg::LVL_MAIN
      |=> cap_wreg_ff[3] == $past(wreg_ff[5][3]))
    else $error("main level set not logged");
  a_cap_maddr: assert property (
    take && cur_level == ccl_pkg::LVL_FOUR
      |=> cap_maddr_ff == $past(maddr_ff[1]))
    else $error("logged micro address not from the error moment");
  a_cap_mret: assert property (
    take && cur_level == ccl_pkg::LVL_TWO
      |=> cap_mret_ff == $past(mret_ff[3]))
    else $error("logged return address not from the error moment");
  a_steal_maddr: assert property (
    take && cur_level == ccl_pkg::LVL_STEAL
      |=> cap_maddr_ff == $past(maddr_ff[4]))
    else $error("steal did not log level one micro address");

  // ==========================================
  // checks: freeze and status
  a_frozen_rise: assert property (
    !frozen_ff && !err_strobe |=> !frozen_ff)
    else $error("record froze with no error");
  a_clear_frees: assert property (
    frozen_ff && clear_wr |=> !frozen_ff)
    else $error("clear left the record frozen");
  a_drop_ignored: assert property (
    frozen_ff && err_strobe |=> $stable(cap_chan_ff) && $stable(cap_flags_ff)
      && $stable(cap_valid_ff) && $stable(cap_wreg_ff[7]))
    else $error("later error reached the frozen record");
  a_drop_flag: assert property (
    frozen_ff && err_strobe |=> istat_ff[ccl_pkg::IRQ_DROPPED])
    else $error("dropped error not flagged");
  a_take_flag: assert property (
    take |=> istat_ff[ccl_pkg::IRQ_CAPTURE])
    else $error("capture not flagged");
  a_istat_clear: assert property (
    istat_wr && reg_wdata[ccl_pkg::IRQ_CAPTURE] && !take
      |=> !istat_ff[ccl_pkg::IRQ_CAPTURE])
    else $error("write-one did not clear capture flag");
  a_irq_masked: assert property (
    imask_ff == 2'h0 && !imask_wr |=> !irq_ff)
    else $error("irq raised with every source masked");
  a_read_state: assert property (
    reg_rd && reg_addr == ccl_pkg::REG_STATE
      |=> rdata_ff == {14'h0000, $past(cap_valid_ff), $past(frozen_ff)})
    else $error("state register read wrong");
  a_read_level: assert property (
    reg_rd && reg_addr == ccl_pkg::REG_LEVEL |=> rdata_ff[7:0] == $past(cap_level_ff))
    else $error("level code read wrong");

  c_capture:  cover property (take ##[1:100] clear_wr);
  c_dropped:  cover property (frozen_ff && err_strobe);
  c_steal:    cover property (take && cur_level == ccl_pkg::LVL_STEAL);
  c_invalid:  cover property (take && lvl_bad);
  c_clr_drop: cover property (clear_wr && dropped);
endmodule

// file: hw/ccl_pkg.sv
// constants, field layouts and carrier types of the controller check logout
// assumes one controller clock and a synchronous active-high reset
// Summary of operation
// - eight condition flags: flag, positive, negative, zero, carry, high, low, equal
// - flags change only on flag-affecting operations, otherwise hold last result
// - level code: 00 L5, 01 L4, 02 steal, 03 L3, 04 L2, 05 L1, 07 main
// - cycle-steal code logs the level one register set
// - level code invalid when channel bits 1 and 6, or 0 and 6, are set
// - invalid level code makes work and address registers invalid too
// - controller bit 0 storage data parity, bit 1 micro-operation parity
// - controller bits 2 and 3 flag storage-gate parity during moves and ALU work
// - controller bits 4,5 storage address status; bits 6,7 unused
// - channel bits 0,1,2,3,5,6 flag checks; bits 4 and 7 unused
// - error logs the eight work registers of the indicated level
// - logged micro address is failing microinstruction address plus one
// - return register holds address after last branch-and-link on that level
// - logged values are the state at the moment of the error
package ccl_pkg;
  // ==========================================
  // level codes
  localparam logic [7:0] LVL_FIVE  = 8'h00;
  localparam logic [7:0] LVL_FOUR  = 8'h01;
  localparam logic [7:0] LVL_STEAL = 8'h02;
  localparam logic [7:0] LVL_THREE = 8'h03;
  localparam logic [7:0] LVL_TWO   = 8'h04;
  localparam logic [7:0] LVL_ONE   = 8'h05;
  localparam logic [7:0] LVL_MAIN  = 8'h07;
  localparam int         NUM_BANKS = 6;
  localparam int         NUM_WREGS = 8;
  // ==========================================
  // register offsets
  localparam logic [4:0] REG_FLAGS   = 5'h00;
  localparam logic [4:0] REG_LEVEL   = 5'h01;
  localparam logic [4:0] REG_CTLERR  = 5'h02;
  localparam logic [4:0] REG_CHANERR = 5'h03;
  localparam logic [4:0] REG_STATE   = 5'h04;
  localparam logic [4:0] REG_ISTAT   = 5'h05;
  localparam logic [4:0] REG_IMASK   = 5'h06;
  localparam logic [4:0] REG_CTRL    = 5'h07;
  localparam logic [4:0] REG_MADDR   = 5'h08;
  localparam logic [4:0] REG_MRET    = 5'h09;
  localparam logic [4:0] REG_LIVEFLG = 5'h0A;
  localparam logic [1:0] REG_WREG_HI = 2'h2;
  // ==========================================
  // field positions and reset values
  localparam int         ST_FROZEN   = 0;
  localparam int         ST_VALID    = 1;
  localparam int         IRQ_CAPTURE = 0;
  localparam int         IRQ_DROPPED = 1;
  localparam int         CTRL_CLEAR  = 0;
  localparam logic [1:0] IRQ_RESET   = 2'h0;
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  // ==========================================
  // carriers; packed msb first, so bit 7 is listed first
  typedef struct packed {
    logic equal, low, high, carry, zero, negative, positive, flag;
  } ccl_flags_t;
  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] addr_status;
    logic gate_par_b;
    logic gate_par_a;
    logic microop_par;
    logic sdr_par;
  } ccl_ctl_err_t;
  typedef struct packed {
    logic unused7;
    logic cycle_steal;
    logic sys_bus_par;
    logic unused4;
    logic io_timeout;
    logic inbound_par;
    logic bad_dev_addr;
    logic outbound_par;
  } ccl_chan_err_t;
endpackage

// file: bench/ccl_reader.sv
// partner: error-recording reader that dumps the logout record and rearms it
// assumes the bench hands it the register port while busy is high
`timescale 1ns/1ps
module ccl_reader (
  // clock, reset and trigger
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        start,
  // register port
  output logic      [4:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata,
  // dump result
  output logic             busy,
  output logic      [15:0] rec [0:31]
);
  logic [4:0] a;
  // ==========
  // reader sequence
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, busy} = '0;
    forever begin
      @(posedge ref_clk);
      if (start && !reset) begin
        busy <= 1'b1;
        // whole record first, rearm only at the very end
        for (int i = 0; i < 18; i++) begin
          a = (i < 10) ? 5'(i) : 5'(i + 6);
          reg_rd <= 1'b1;
          reg_addr <= a;
          @(posedge ref_clk);
          reg_rd <= 1'b0;
          // released address shows junk, not the last value
          reg_addr <= ~a;
          #1 rec[a] = reg_rdata;
          @(posedge ref_clk);
        end
        reg_wr <= 1'b1;
        reg_addr <= ccl_pkg::REG_ISTAT;
        reg_wdata <= rec[5];
        @(posedge ref_clk);
        reg_addr <= ccl_pkg::REG_CTRL;
        reg_wdata <= 16'h0001;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_wdata <= 16'hFFFF;
        busy <= 1'b0;
      end
    end
  end
endmodule

// file: bench/test_controller_check_logout.sv
// bench: random and corner runs of the controller check logout
// assumes ccl_pkg, ccl_logout and the reader model are compiled first
`timescale 1ns/1ps
module test_controller_check_logout;
  // ==========
  // signals and expectation model
  localparam logic [7:0] CODES [0:7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h06};
  logic                   ref_clk, reset, op_valid, op_sets_flags, wr_we, ex_valid, bl_valid;
  logic                   err_strobe, b_wr, b_rd, r_wr, r_rd, busy, start, irq, frozen;
  ccl_pkg::ccl_flags_t    op_flags;
  ccl_pkg::ccl_ctl_err_t  err_ctl;
  ccl_pkg::ccl_chan_err_t err_chan;
  logic [7:0]             cur_level, wr_level, ex_level, bl_level;
  logic [2:0]             wr_idx;
  logic [15:0]            wr_data, ex_addr, bl_addr, b_wdata, r_wdata, reg_rdata;
  logic [4:0]             b_addr, r_addr;
  logic [15:0]            rec [0:31];
  logic [15:0]            wm [0:7][0:7];
  int                     mismatches, comparisons;

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  ccl_logout i_dut (
    .ref_clk(ref_clk), .reset(reset), .op_valid(op_valid), .op_sets_flags(op_sets_flags),
    .op_flags(op_flags), .cur_level(cur_level), .wr_we(wr_we), .wr_level(wr_level),
    .wr_idx(wr_idx), .wr_data(wr_data), .ex_valid(ex_valid), .ex_level(ex_level),
    .ex_addr(ex_addr), .bl_valid(bl_valid), .bl_level(bl_level), .bl_addr(bl_addr),
    .err_strobe(err_strobe), .err_ctl(err_ctl), .err_chan(err_chan),
    .reg_addr(busy ? r_addr : b_addr), .reg_wdata(busy ? r_wdata : b_wdata),
    .reg_wr(busy ? r_wr : b_wr), .reg_rd(busy ? r_rd : b_rd), .reg_rdata(reg_rdata),
    .irq(irq), .frozen(frozen));

  ccl_reader i_reader (
    .ref_clk(ref_clk), .reset(reset), .start(start), .reg_addr(r_addr), .reg_wdata(r_wdata),
    .reg_wr(r_wr), .reg_rd(r_rd), .reg_rdata(reg_rdata), .busy(busy), .rec(rec));

  // ==========
  // checks, bus tasks and closing
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    b_wr <= 1'b1;
    b_addr <= a;
    b_wdata <= d;
    @(posedge ref_clk);
    b_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    b_rd <= 1'b1;
    b_addr <= a;
    @(posedge ref_clk);
    b_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (busy !== 1'b0) begin
      @(posedge ref_clk);
      n++;
      if (n > 200) begin
        mismatches++;
        summarize();
      end
    end
  endtask
  // steal shares the level one bank; main and unknown codes share one
  function automatic int bk(input logic [7:0] c);
    if (c == ccl_pkg::LVL_STEAL) return 5;
    if (c <= 8'h05) return int'(c);
    return 7;
  endfunction

  // ==========
  // main sequence
  initial begin
    logic [15:0]         d, ea, ba;
    logic [7:0]          lvl, cc, ch;
    logic [1:0]          mask;
    logic                ok;
    ccl_pkg::ccl_flags_t f;
    int                  b;
    reset = 1'b1;
    {op_valid, op_sets_flags, wr_we, ex_valid, bl_valid, err_strobe, b_wr, b_rd, start} = '0;
    {op_flags, err_ctl, err_chan, cur_level, wr_level, ex_level, bl_level} = '0;
    {wr_idx, wr_data, ex_addr, bl_addr, b_addr, b_wdata} = '0;
    void'($urandom(32'h9E6D));
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    // read-only write ignored, all cleared, 0B unmapped
    wr(ccl_pkg::REG_FLAGS, 16'hFFFF);
    for (int a = 0; a < 12; a++) begin
      rd(5'(a), d);
      chk_word(d, 16'h0000);
    end
    $display("test reset_readonly done");
    for (int i = 0; i < 8; i++) begin
      lvl = CODES[i];
      b = bk(lvl);
      mask = 2'($urandom);
      wr(ccl_pkg::REG_IMASK, {14'h0000, mask});
      for (int k = 0; k < 8; k++) begin
        @(posedge ref_clk);
        d = 16'($urandom);
        wr_we <= 1'b1;
        wr_level <= (lvl == ccl_pkg::LVL_STEAL) ? ccl_pkg::LVL_ONE : lvl;
        wr_idx <= 3'(k);
        wr_data <= d;
        wm[b][k] = d;
      end
      @(posedge ref_clk);
      f = 8'($urandom);
      ea = 16'($urandom);
      ba = 16'($urandom);
      wr_we <= 1'b0;
      {ex_valid, bl_valid, op_valid, op_sets_flags} <= 4'hF;
      {ex_level, bl_level, cur_level} <= {3{lvl}};
      {ex_addr, bl_addr, op_flags} <= {ea, ba, f};
      @(posedge ref_clk);
      // op outside the flag classes must leave f in place
      {ex_valid, bl_valid, op_sets_flags} <= 3'h0;
      op_flags <= ~f;
      @(posedge ref_clk);
      cc = {2'($urandom), 2'(i), 4'($urandom)};
      ch = (i == 0) ? 8'h42 : (i == 1) ? 8'h41 : 8'($urandom);
      // error edge carries updates that must not reach the log
      {err_strobe, ex_valid, op_sets_flags, wr_we} <= 4'hF;
      {err_ctl, err_chan, ex_addr, wr_idx, wr_data} <= {cc, ch, ~ea, 3'h0, ~wm[b][0]};
      @(posedge ref_clk);
      {err_strobe, ex_valid, op_valid, op_sets_flags, wr_we} <= 5'h00;
      #1 chk_bit(frozen, 1'b1);
      @(posedge ref_clk);
      #1 chk_bit(irq, mask[0]);
      @(posedge ref_clk);
      err_strobe <= 1'b1;
      {err_ctl, err_chan} <= {~cc, ~ch};
      @(posedge ref_clk);
      err_strobe <= 1'b0;
      @(posedge ref_clk);
      #1 chk_bit(irq, |mask);
      @(posedge ref_clk);
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      wait_idle();
      #1 chk_bit(frozen, 1'b0);
      chk_bit(irq, 1'b0);
      ok = !(ch[6] && (ch[1] || ch[0]));
      chk_word(rec[0], {8'h00, f});
      chk_word(rec[1], {8'h00, lvl});
      chk_word(rec[2], {8'h00, cc & 8'h3F});
      chk_word(rec[3], {8'h00, ch & 8'h6F});
      chk_word(rec[4], {14'h0000, ok, 1'b1});
      chk_word(rec[5], 16'h0003);
      if (ok) begin
        chk_word(rec[8], ea + 16'h0001);
        chk_word(rec[9], ba + 16'h0001);
        for (int k = 0; k < 8; k++) chk_word(rec[16 + k], wm[b][k]);
      end
      rd(ccl_pkg::REG_LIVEFLG, d);
      chk_word(d, {8'h00, ~f});
      $display("test level %h done", lvl);
    end
    summarize();
  end
endmodule
